// file: config_host.sv
// Host model issuing one-cycle register write and read strobes
`timescale 1ns/1ns
`default_nettype none
module config_host (
    input  wire logic                      clk,
    input  wire logic [7:0]                rd_data,
    input  wire logic                      rd_valid,
    input  wire logic                      rd_hit,
    output var reference_path_pkg::reg_req_t reg_req
);
    initial reg_req = '0;
    // Released bus shows inverted values, never the stale request
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        reg_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v, output logic h);
        @(posedge clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        reg_req <= '{1'b0, 1'b0, ~a, 8'hFF};
        #1;
        d = rd_data;
        v = rd_valid;
        h = rd_hit;
    endtask : read_reg
endmodule : config_host
`default_nettype wire

// file: override_select.sv
// Chooses between a strap-derived setting and a programmed one
`timescale 1ns/1ns
`default_nettype none
module override_select #(
    parameter int           W = 1
) (
    input  wire logic           override_en,
    input  wire logic [W-1:0]   reg_value,
    input  wire logic [W-1:0]   strap_value,
    output logic [W-1:0]        selected
);

    if (W < 1) begin : g_width_check
        $error("override_select: W must be at least 1");
    end

    // Strap value wins unless software asks otherwise
    assign selected = override_en ? reg_value : strap_value;

endmodule : override_select
`default_nettype wire

// file: reference_path_config_regs.sv
// Reference path configuration registers: second reference, crystal divider, switchover
//
// Summary of operation
// - Second reference divider is 14 bits: high byte at 0x23, low six at 0x24[7:2].
// - Second reference divider register resets to 4096.
// - 0x24[1] selects programmed second divider, else strap-derived ratio.
// - 0x25[7] clear: doubler chosen from straps; set: bit 6 decides.
// - Under override, 0x25[6] zero bypasses doubler, one inserts it.
// - 0x25[5] clear: prescaler chosen from straps; set: bit 4 decides.
// - Under override, 0x25[4] zero bypasses divide-by-5, one inserts it.
// - Crystal divider is 14 bits: high byte at 0x27, low six at 0x28[7:2].
// - Crystal divider register resets to 2048.
// - 0x28[1] selects programmed crystal divider, else strap-derived ratio.
// - 0x29[7:6] decodes revertive, nonrevertive, force primary, force secondary.
// - 0x29[5] makes inputs one differential pair, disabling secondary and switchover.
// - 0x26, 0x2A to 0x31, 0x24[0], 0x25[3:0] have no function.
`timescale 1ns/1ns
`default_nettype none
module reference_path_config_regs (
    input  wire logic                                   clk,
    input  wire logic                                   rstn,
    input  wire reference_path_pkg::reg_req_t           reg_req,
    output logic [reference_path_pkg::REG_W-1:0]        rd_data,
    output logic                                        rd_valid,
    output logic                                        rd_hit,
    input  wire logic [reference_path_pkg::RATIO_W-1:0] strap_second_ratio,
    input  wire logic                                   strap_second_doubler,
    input  wire logic                                   strap_second_prescaler,
    input  wire logic [reference_path_pkg::RATIO_W-1:0] strap_crystal_ratio,
    output reference_path_pkg::second_ref_path_t        second_ref_path,
    output logic [reference_path_pkg::RATIO_W-1:0]      crystal_path_divide_ratio,
    output reference_path_pkg::switchover_cfg_t         switchover_cfg
);

    localparam int RW = reference_path_pkg::RATIO_W;
    localparam int LW = reference_path_pkg::LOW_FIELD_W;

    // Address decode
    wire a_sec_hi  = reg_req.addr == reference_path_pkg::ADDR_SECOND_DIV_HIGH;
    wire a_sec_lo  = reg_req.addr == reference_path_pkg::ADDR_SECOND_DIV_LOW;
    wire a_sec_dp  = reg_req.addr == reference_path_pkg::ADDR_SECOND_DBL_PRE;
    wire a_xo_hi   = reg_req.addr == reference_path_pkg::ADDR_CRYSTAL_DIV_HIGH;
    wire a_xo_lo   = reg_req.addr == reference_path_pkg::ADDR_CRYSTAL_DIV_LOW;
    wire a_switch  = reg_req.addr == reference_path_pkg::ADDR_SWITCHOVER;
    // Spare addresses still belong to this slice so they answer zero
    wire a_in_range = (reg_req.addr >= reference_path_pkg::ADDR_SECOND_DIV_HIGH) &&
                      (reg_req.addr <= reference_path_pkg::ADDR_SPARE_LAST);

    wire w_sec_hi  = reg_req.wr & a_sec_hi;
    wire w_sec_lo  = reg_req.wr & a_sec_lo;
    wire w_sec_dp  = reg_req.wr & a_sec_dp;
    wire w_xo_hi   = reg_req.wr & a_xo_hi;
    wire w_xo_lo   = reg_req.wr & a_xo_lo;
    wire w_switch  = reg_req.wr & a_switch;

    // Control bits
    logic                               sec_ratio_en_r;
    logic                               sec_ratio_en_nxt;
    logic                               dbl_ovr_r;
    logic                               dbl_ovr_nxt;
    logic                               dbl_sel_r;
    logic                               dbl_sel_nxt;
    logic                               pre_ovr_r;
    logic                               pre_ovr_nxt;
    logic                               pre_sel_r;
    logic                               pre_sel_nxt;
    logic                               xo_ratio_en_r;
    logic                               xo_ratio_en_nxt;
    reference_path_pkg::switch_mode_t   mode_r;
    reference_path_pkg::switch_mode_t   mode_nxt;
    logic                               diff_r;
    logic                               diff_nxt;

    assign sec_ratio_en_nxt = w_sec_lo ? reg_req.wdata[reference_path_pkg::LOW_ENABLE_BIT] : sec_ratio_en_r;
    assign dbl_ovr_nxt      = w_sec_dp ? reg_req.wdata[reference_path_pkg::DBL_OVR_BIT] : dbl_ovr_r;
    assign dbl_sel_nxt      = w_sec_dp ? reg_req.wdata[reference_path_pkg::DBL_SEL_BIT] : dbl_sel_r;
    assign pre_ovr_nxt      = w_sec_dp ? reg_req.wdata[reference_path_pkg::PRE_OVR_BIT] : pre_ovr_r;
    assign pre_sel_nxt      = w_sec_dp ? reg_req.wdata[reference_path_pkg::PRE_SEL_BIT] : pre_sel_r;
    assign xo_ratio_en_nxt  = w_xo_lo  ? reg_req.wdata[reference_path_pkg::LOW_ENABLE_BIT] : xo_ratio_en_r;
    assign mode_nxt         = w_switch ?
        reference_path_pkg::switch_mode_t'(reg_req.wdata[reference_path_pkg::MODE_MSB:reference_path_pkg::MODE_LSB])
        : mode_r;
    assign diff_nxt         = w_switch ? reg_req.wdata[reference_path_pkg::DIFF_BIT] : diff_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sec_ratio_en_r <= 1'b0;
            dbl_ovr_r      <= 1'b0;
            dbl_sel_r      <= 1'b0;
            pre_ovr_r      <= 1'b0;
            pre_sel_r      <= 1'b0;
            xo_ratio_en_r  <= 1'b0;
            mode_r         <= reference_path_pkg::MODE_REVERTIVE;
            diff_r         <= 1'b0;
        end else begin
            sec_ratio_en_r <= sec_ratio_en_nxt;
            dbl_ovr_r      <= dbl_ovr_nxt;
            dbl_sel_r      <= dbl_sel_nxt;
            pre_ovr_r      <= pre_ovr_nxt;
            pre_sel_r      <= pre_sel_nxt;
            xo_ratio_en_r  <= xo_ratio_en_nxt;
            mode_r         <= mode_nxt;
            diff_r         <= diff_nxt;
        end
    end

    // Divider storage
    logic [RW-1:0] sec_staged;
    logic [RW-1:0] sec_applied;
    logic [RW-1:0] xo_staged;
    logic [RW-1:0] xo_applied;

    split_divider_stage #(
        .W           (RW),
        .LOW_W       (LW),
        .RESET_VALUE (reference_path_pkg::SECOND_DIV_RESET)
    ) u_second_div (
        .clk     (clk),
        .rstn    (rstn),
        .high_wr (w_sec_hi),
        .low_wr  (w_sec_lo),
        .wdata   (reg_req.wdata),
        .staged  (sec_staged),
        .applied (sec_applied)
    );

    split_divider_stage #(
        .W           (RW),
        .LOW_W       (LW),
        .RESET_VALUE (reference_path_pkg::CRYSTAL_DIV_RESET)
    ) u_crystal_div (
        .clk     (clk),
        .rstn    (rstn),
        .high_wr (w_xo_hi),
        .low_wr  (w_xo_lo),
        .wdata   (reg_req.wdata),
        .staged  (xo_staged),
        .applied (xo_applied)
    );

    // Effective settings
    logic [RW-1:0] sec_ratio_sel;
    logic [RW-1:0] xo_ratio_sel;
    logic          dbl_sel;
    logic          pre_sel;

    override_select #(.W(RW)) u_sel_sec_ratio (
        .override_en (sec_ratio_en_r),
        .reg_value   (sec_applied),
        .strap_value (strap_second_ratio),
        .selected    (sec_ratio_sel)
    );

    override_select #(.W(RW)) u_sel_xo_ratio (
        .override_en (xo_ratio_en_r),
        .reg_value   (xo_applied),
        .strap_value (strap_crystal_ratio),
        .selected    (xo_ratio_sel)
    );

    override_select #(.W(1)) u_sel_dbl (
        .override_en (dbl_ovr_r),
        .reg_value   (dbl_sel_r),
        .strap_value (strap_second_doubler),
        .selected    (dbl_sel)
    );

    override_select #(.W(1)) u_sel_pre (
        .override_en (pre_ovr_r),
        .reg_value   (pre_sel_r),
        .strap_value (strap_second_prescaler),
        .selected    (pre_sel)
    );

    wire m_revert = mode_r == reference_path_pkg::MODE_REVERTIVE;
    wire m_fprim  = mode_r == reference_path_pkg::MODE_FORCE_PRIMARY;
    wire m_fsec   = mode_r == reference_path_pkg::MODE_FORCE_SECONDARY;

    reference_path_pkg::second_ref_path_t path_nxt;
    reference_path_pkg::switchover_cfg_t  sw_nxt;

    assign path_nxt.second_ref_divide_ratio   = sec_ratio_sel;
    assign path_nxt.second_ref_doubler        = dbl_sel;
    assign path_nxt.second_ref_div5_prescaler = pre_sel;

    assign sw_nxt.mode                          = mode_r;
    assign sw_nxt.revertive                     = m_revert;
    assign sw_nxt.force_primary                 = m_fprim;
    assign sw_nxt.force_secondary               = m_fsec;
    // differential pair disables secondary and switchover
    assign sw_nxt.switchover_enable             = ~diff_r;
    assign sw_nxt.secondary_channel_enable      = ~diff_r;
    assign sw_nxt.differential_reference_enable = diff_r;

    // Read-back mux
    logic [reference_path_pkg::REG_W-1:0] rd_mux;

    always_comb begin
        rd_mux = reference_path_pkg::REG_ZERO;
        case (1'b1)
            a_sec_hi: begin
                rd_mux = sec_staged[RW-1:LW];
            end
            a_sec_lo: begin
                rd_mux[reference_path_pkg::REG_W-1:reference_path_pkg::LOW_RATIO_LSB] = sec_staged[LW-1:0];
                rd_mux[reference_path_pkg::LOW_ENABLE_BIT]  = sec_ratio_en_r;
            end
            a_sec_dp: begin
                rd_mux[reference_path_pkg::DBL_OVR_BIT] = dbl_ovr_r;
                rd_mux[reference_path_pkg::DBL_SEL_BIT] = dbl_sel_r;
                rd_mux[reference_path_pkg::PRE_OVR_BIT] = pre_ovr_r;
                rd_mux[reference_path_pkg::PRE_SEL_BIT] = pre_sel_r;
            end
            a_xo_hi: begin
                rd_mux = xo_staged[RW-1:LW];
            end
            a_xo_lo: begin
                rd_mux[reference_path_pkg::REG_W-1:reference_path_pkg::LOW_RATIO_LSB] = xo_staged[LW-1:0];
                rd_mux[reference_path_pkg::LOW_ENABLE_BIT]  = xo_ratio_en_r;
            end
            a_switch: begin
                rd_mux[reference_path_pkg::MODE_MSB:reference_path_pkg::MODE_LSB] = mode_r;
                rd_mux[reference_path_pkg::DIFF_BIT] = diff_r;
            end
            default: begin
                rd_mux = reference_path_pkg::REG_ZERO;
            end
        endcase
    end

    // Outputs registered so downstream dividers see glitch-free values
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data                   <= reference_path_pkg::REG_ZERO;
            rd_valid                  <= 1'b0;
            rd_hit                    <= 1'b0;
            second_ref_path           <= '0;
            crystal_path_divide_ratio <= '0;
            switchover_cfg            <= '0;
        end else begin
            rd_data                   <= reg_req.rd ? rd_mux : reference_path_pkg::REG_ZERO;
            rd_valid                  <= reg_req.rd;
            rd_hit                    <= reg_req.rd & a_in_range;
            second_ref_path           <= path_nxt;
            crystal_path_divide_ratio <= xo_ratio_sel;
            switchover_cfg            <= sw_nxt;
        end
    end

endmodule : reference_path_config_regs
`default_nettype wire

// file: reference_path_config_regs_properties.sv
// Port-level checks for the reference path configuration registers
`timescale 1ns/1ns
`default_nettype none
module reference_path_config_regs_properties (
    input wire logic                                 clk,
    input wire logic                                 rstn,
    input wire reference_path_pkg::reg_req_t         reg_req,
    input wire logic [7:0]                           rd_data,
    input wire logic                                 rd_valid,
    input wire logic                                 rd_hit,
    input wire logic                                 strap_second_doubler,
    input wire logic                                 strap_second_prescaler,
    input wire logic [13:0]                          strap_second_ratio,
    input wire logic [13:0]                          strap_crystal_ratio,
    input wire reference_path_pkg::second_ref_path_t second_ref_path,
    input wire logic [13:0]                          crystal_path_divide_ratio,
    input wire reference_path_pkg::switchover_cfg_t  switchover_cfg
);
    logic [1:0] live_r;
    logic [7:0] wd1_r;
    logic [7:0] wd2_r;
    wire logic [7:0] a      = reg_req.addr;
    wire logic [7:0] d      = reg_req.wdata;
    wire logic       wr     = reg_req.wr;
    wire logic       rd     = reg_req.rd;
    wire logic       in_map = a >= 8'h23 && a <= 8'h31;
    wire logic       ready  = live_r == 2'h3;
    // Outputs hold zero for a cycle after reset, so decode checks wait
    always_ff @(posedge clk) begin
        live_r <= !rstn ? 2'h0 : (ready ? live_r : live_r + 2'h1);
        wd1_r  <= d;
        wd2_r  <= wd1_r;
    end
    function automatic logic [7:0] unused_mask(input logic [7:0] x);
        case (x)
            8'h24, 8'h28: return 8'h01;
            8'h25:        return 8'h0F;
            8'h29:        return 8'h1F;
            default:      return 8'h00;
        endcase
    endfunction : unused_mask
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    read_hit_a: assert property (rd && in_map |=> rd_valid && rd_hit)
        else $error("mapped read not answered with hit");
    read_miss_a: assert property (rd && !in_map |=> rd_valid && !rd_hit && rd_data == 8'h00)
        else $error("unmapped read not zero without hit");
    unused_bits_a: assert property (rd |=> (rd_data & unused_mask($past(a))) == 8'h00)
        else $error("unused bits read nonzero");
    mode_decode_a: assert property (ready |-> switchover_cfg.force_primary == (switchover_cfg.mode == 2'b10)
        && switchover_cfg.force_secondary == (switchover_cfg.mode == 2'b11)
        && switchover_cfg.revertive == (switchover_cfg.mode == 2'b00))
        else $error("switchover mode decode wrong");
    diff_disable_a: assert property (ready |-> switchover_cfg.switchover_enable
        == !switchover_cfg.differential_reference_enable
        && switchover_cfg.secondary_channel_enable == !switchover_cfg.differential_reference_enable)
        else $error("differential option enables wrong");
    mode_write_a: assert property (wr && a == 8'h29 |-> ##2 switchover_cfg.mode == wd2_r[7:6]
        && switchover_cfg.differential_reference_enable == wd2_r[5])
        else $error("switchover write not applied");
    dbl_force_a: assert property (wr && a == 8'h25 && d[7] |-> ##2
        second_ref_path.second_ref_doubler == wd2_r[6])
        else $error("doubler select not applied");
    pre_force_a: assert property (wr && a == 8'h25 && d[5] |-> ##2
        second_ref_path.second_ref_div5_prescaler == wd2_r[4])
        else $error("prescaler select not applied");
    dbl_strap_a: assert property (wr && a == 8'h25 && !d[7] |-> ##2
        second_ref_path.second_ref_doubler == $past(strap_second_doubler))
        else $error("doubler not from straps");
    pre_strap_a: assert property (wr && a == 8'h25 && !d[5] |-> ##2
        second_ref_path.second_ref_div5_prescaler == $past(strap_second_prescaler))
        else $error("prescaler not from straps");
    second_strap_a: assert property (wr && a == 8'h24 && !d[1] |-> ##2
        second_ref_path.second_ref_divide_ratio == $past(strap_second_ratio))
        else $error("second ratio not from straps");
    crystal_strap_a: assert property (wr && a == 8'h28 && !d[1] |-> ##2
        crystal_path_divide_ratio == $past(strap_crystal_ratio))
        else $error("crystal ratio not from straps");
    cover property (rd && !in_map);
    cover property (wr && a == 8'h25 && d[7]);
    cover property (ready && switchover_cfg.differential_reference_enable);
endmodule : reference_path_config_regs_properties
bind reference_path_config_regs reference_path_config_regs_properties u_props (
    .clk, .rstn, .reg_req, .rd_data, .rd_valid, .rd_hit, .strap_second_doubler, .strap_second_prescaler,
    .strap_second_ratio,
    .strap_crystal_ratio, .second_ref_path, .crystal_path_divide_ratio, .switchover_cfg);
`default_nettype wire

// file: reference_path_config_regs_tb.sv
// Self-checking bench for the reference path configuration registers
`timescale 1ns/1ns
`default_nettype none
module reference_path_config_regs_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    reference_path_pkg::reg_req_t         reg_req;
    reference_path_pkg::second_ref_path_t sp;
    reference_path_pkg::switchover_cfg_t  sw;
    logic [7:0]  rd_data, rv;
    logic        rd_valid, rd_hit, vv, hv;
    logic [13:0] s_ratio = 14'h0123, x_ratio = 14'h0456, xr;
    logic        s_dbl = 1'b0, s_pre = 1'b0;
    int          num_errors = 0, n_compared = 0;
    logic [7:0]  map_a [11] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h31, 8'h32};
    logic [7:0]  map_d [11] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  dp_w [5] = '{8'hFF, 8'hA0, 8'h50, 8'h50, 8'h20};
    logic [1:0]  dp_s [5] = '{2'b00, 2'b11, 2'b00, 2'b11, 2'b11};
    logic [1:0]  dp_e [5] = '{2'b11, 2'b00, 2'b00, 2'b11, 2'b10};
    always #2 clk = ~clk;
    config_host host (.clk, .rd_data, .rd_valid, .rd_hit, .reg_req);
    reference_path_config_regs DUT (.clk, .rstn, .reg_req, .rd_data, .rd_valid, .rd_hit,
        .strap_second_ratio(s_ratio), .strap_second_doubler(s_dbl), .strap_second_prescaler(s_pre),
        .strap_crystal_ratio(x_ratio), .second_ref_path(sp), .crystal_path_divide_ratio(xr),
        .switchover_cfg(sw));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_expect(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rv, vv, hv);
        check({vv, hv, rv}, {1'b1, a >= 8'h23 && a <= 8'h31, exp});
    endtask : rd_expect
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    function automatic logic [7:0] exp_sw(input logic [1:0] m, input logic df);
        return {m, m == 2'b00, m == 2'b10, m == 2'b11, !df, !df, df};
    endfunction : exp_sw
    function automatic logic [13:0] ratio_of(input int j);
        return j ? xr : sp.second_ref_divide_ratio;
    endfunction : ratio_of
    task automatic after_reset();
        repeat (3) @(posedge clk);
        #1;
        check(sp, {s_ratio, s_dbl, s_pre});
        check(xr, x_ratio);
        check(sw, exp_sw(2'b00, 1'b0));
        for (int i = 0; i < 11; i++) rd_expect(map_a[i], map_d[i]);
        $display("test reset values done");
    endtask : after_reset
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        after_reset();
        for (int j = 0; j < 2; j++) begin
            // Low byte alone must not reach the divider
            host.write_reg(8'h24 + 8'(4 * j), 8'h37);
            settle();
            check(ratio_of(j), j ? 14'h0800 : 14'h1000);
            host.write_reg(8'h23 + 8'(4 * j), 8'h12);
            settle();
            check(ratio_of(j), 14'h048D);
            host.write_reg(8'h23 + 8'(4 * j), 8'h3F);
            settle();
            check(ratio_of(j), 14'h048D);
            rd_expect(8'h23 + 8'(4 * j), 8'h3F);
            rd_expect(8'h24 + 8'(4 * j), 8'h36);
            host.write_reg(8'h24 + 8'(4 * j), 8'hFE);
            settle();
            check(ratio_of(j), 14'h0FFF);
            host.write_reg(8'h24 + 8'(4 * j), 8'h00);
            @(posedge clk);
            s_ratio <= 14'h2AAA;
            x_ratio <= 14'h1555;
            settle();
            check(ratio_of(j), j ? 14'h1555 : 14'h2AAA);
        end
        $display("test dividers done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            {s_dbl, s_pre} <= dp_s[i];
            host.write_reg(8'h25, dp_w[i]);
            settle();
            check({sp.second_ref_doubler, sp.second_ref_div5_prescaler}, dp_e[i]);
            rd_expect(8'h25, dp_w[i] & 8'hF0);
        end
        $display("test doubler prescaler done");
        for (int i = 0; i < 8; i++) begin
            host.write_reg(8'h29, 8'(i << 5) | 8'h1F);
            settle();
            check(sw, exp_sw(2'(i >> 1), i[0]));
            rd_expect(8'h29, 8'(i << 5));
        end
        host.write_reg(8'h26, 8'hFF);
        host.write_reg(8'h2A, 8'hFF);
        rd_expect(8'h26, 8'h00);
        rd_expect(8'h2A, 8'h00);
        $display("test switchover done");
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        after_reset();
        conclude();
    end
endmodule : reference_path_config_regs_tb
`default_nettype wire

// file: reference_path_pkg.sv
// Register map, field layout and carrier types of the reference path configuration slice
package reference_path_pkg;

    localparam int RATIO_W      = 14;
    localparam int LOW_FIELD_W  = 6;
    localparam int REG_W        = 8;
    localparam int ADDR_W       = 8;

    localparam logic [ADDR_W-1:0] ADDR_SECOND_DIV_HIGH  = 8'h23;
    localparam logic [ADDR_W-1:0] ADDR_SECOND_DIV_LOW   = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_SECOND_DBL_PRE   = 8'h25;
    localparam logic [ADDR_W-1:0] ADDR_SECOND_SPARE     = 8'h26;
    localparam logic [ADDR_W-1:0] ADDR_CRYSTAL_DIV_HIGH = 8'h27;
    localparam logic [ADDR_W-1:0] ADDR_CRYSTAL_DIV_LOW  = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_SWITCHOVER       = 8'h29;
    localparam logic [ADDR_W-1:0] ADDR_SPARE_FIRST      = 8'h2A;
    localparam logic [ADDR_W-1:0] ADDR_SPARE_LAST       = 8'h31;

    // Field positions
    localparam int LOW_RATIO_LSB  = 2;
    localparam int LOW_ENABLE_BIT = 1;
    localparam int DBL_OVR_BIT    = 7;
    localparam int DBL_SEL_BIT    = 6;
    localparam int PRE_OVR_BIT    = 5;
    localparam int PRE_SEL_BIT    = 4;
    localparam int MODE_MSB       = 7;
    localparam int MODE_LSB       = 6;
    localparam int DIFF_BIT       = 5;

    // Reset values
    localparam logic [RATIO_W-1:0] SECOND_DIV_RESET  = 14'h1000;
    localparam logic [RATIO_W-1:0] CRYSTAL_DIV_RESET = 14'h0800;
    localparam logic [REG_W-1:0]   REG_ZERO          = 8'h00;

    typedef enum logic [1:0] {
        MODE_REVERTIVE       = 2'b00,
        MODE_NONREVERTIVE    = 2'b01,
        MODE_FORCE_PRIMARY   = 2'b10,
        MODE_FORCE_SECONDARY = 2'b11
    } switch_mode_t;

    typedef struct packed {
        logic                    wr;
        logic                    rd;
        logic [ADDR_W-1:0]       addr;
        logic [REG_W-1:0]        wdata;
    } reg_req_t;

    typedef struct packed {
        logic [RATIO_W-1:0]      second_ref_divide_ratio;
        logic                    second_ref_doubler;
        logic                    second_ref_div5_prescaler;
    } second_ref_path_t;

    typedef struct packed {
        switch_mode_t            mode;
        logic                    revertive;
        logic                    force_primary;
        logic                    force_secondary;
        logic                    switchover_enable;
        logic                    secondary_channel_enable;
        logic                    differential_reference_enable;
    } switchover_cfg_t;

endpackage : reference_path_pkg

// file: split_divider_stage.sv
// Two-byte divider register with staging so both halves are applied together
`timescale 1ns/1ns
`default_nettype none
module split_divider_stage #(
    parameter int               W           = 14,
    parameter int               LOW_W       = 6,
    parameter logic [W-1:0]     RESET_VALUE = 14'h1000
) (
    input  wire logic           clk,
    input  wire logic           rstn,
    input  wire logic           high_wr,
    input  wire logic           low_wr,
    input  wire logic [7:0]     wdata,
    output logic [W-1:0]        staged,
    output logic [W-1:0]        applied
);

    // Elaboration check: the high half must be exactly one bus byte
    if (W != LOW_W + 8) begin : g_width_check
        $error("split_divider_stage: W must equal LOW_W + 8");
    end

    logic [W-1:0]   staged_r;
    logic [W-1:0]   staged_nxt;
    logic [W-1:0]   applied_r;
    logic           high_new_r;
    logic           low_new_r;
    wire            high_done = high_new_r | high_wr;
    wire            low_done  = low_new_r | low_wr;
    // Commit only once both halves have fresh content
    wire            commit    = high_done & low_done;

    always_comb begin
        staged_nxt = staged_r;
        if (high_wr) begin
            staged_nxt[W-1:LOW_W] = wdata;
        end
        if (low_wr) begin
            staged_nxt[LOW_W-1:0] = wdata[7:8-LOW_W];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            staged_r   <= RESET_VALUE;
            applied_r  <= RESET_VALUE;
            high_new_r <= 1'b0;
            low_new_r  <= 1'b0;
        end else begin
            staged_r   <= staged_nxt;
            high_new_r <= high_done & ~commit;
            low_new_r  <= low_done & ~commit;
            if (commit) begin
                applied_r <= staged_nxt;
            end
        end
    end

    assign staged  = staged_r;
    assign applied = applied_r;

endmodule : split_divider_stage
`default_nettype wire
